// >>> design/afo_formatter.sv
// afo_formatter.sv: output formatter of a 16-bit sampling converter, AHB-Lite controlled
// assumes: core_word and core_range come from the converter core on hclk;
// the encode clock pins are asynchronous and much slower than hclk
`include "afo_consts.svh"

// What this block does
// - power-down stops analog, tristates both buses, both range flags and both strobes
// - dither enable follows control bit
// - second bus driven only in demux mode
// - first bus carries words in both modes
// - second range flag marks its word's overrange
// - second range flag tristated in full-rate mode
// - first range flag marks its word's overrange
// - second strobe: sample rate, half in demux
// - first strobe is inverse of second
// - style select: demux or full rate; both differential codes act as full rate
// - format select sets coding and stabilizer
// - scramble xors upper bits with bit zero
// - gain select: one when low, 1.5 high
// - sample held on encode rising edge
// - output word appears seven samples later; in demux the first bus word appears eight samples later
module afo_formatter
  import afo_pkg::*;
#(
  parameter int LATENCY = `AFO_LATENCY
) (
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  input  wire logic                   encode_clock_pos,
  input  wire logic                   encode_clock_neg,
  input  wire logic [`AFO_WORD_W-1:0] core_word,
  input  wire logic                   core_range,
  output logic [`AFO_WORD_W-1:0]      first_output_bus,
  output logic                        first_output_bus_oe,
  output logic [`AFO_WORD_W-1:0]      second_output_bus,
  output logic                        second_output_bus_oe,
  output logic                        first_bus_range_flag,
  output logic                        first_bus_range_flag_oe,
  output logic                        second_bus_range_flag,
  output logic                        second_bus_range_flag_oe,
  output logic                        first_bus_valid_strobe,
  output logic                        first_bus_valid_strobe_oe,
  output logic                        second_bus_valid_strobe,
  output logic                        second_bus_valid_strobe_oe,
  output logic                        analog_power_down,
  output logic                        dither_enable,
  output logic                        gain_high,
  output logic                        duty_stabilizer_en
);

  // --------------------------------------------------------------------------
  // state and submodule wires
  // --------------------------------------------------------------------------
  afo_state_t                 s_q;
  afo_state_t                 s_d;
  logic [1:0]                 enc_sync;
  logic                       enc_level;
  logic                       enc_rise;
  logic                       enc_fall;
  logic                       sample_adv;
  logic [`AFO_WORD_W:0]       pipe_out;
  logic [`AFO_WORD_W-1:0]     fmt_word;
  logic                       addr_ok;
  logic                       demux;

  // --------------------------------------------------------------------------
  // encode clock synchroniser and edge detect
  // --------------------------------------------------------------------------
  afo_sync #(
    .W (2)
  ) u_enc_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in ({encode_clock_pos, encode_clock_neg}),
    .sync_out (enc_sync)
  );

  assign enc_level  = enc_sync[1] & ~enc_sync[0];
  assign enc_rise   = enc_level & ~s_q.enc_prev;
  assign enc_fall   = ~enc_level & s_q.enc_prev;
  assign sample_adv = enc_rise & ~s_q.ctrl.pdn;

  // --------------------------------------------------------------------------
  // sample pipeline: word and range flag travel together
  // --------------------------------------------------------------------------
  afo_delay #(
    .DEPTH (LATENCY),
    .W     (`AFO_WORD_W + 1)
  ) u_pipe (
    .hclk    (hclk),
    .hresetn (hresetn),
    .adv     (sample_adv),
    .din     ({core_range, core_word}),
    .dout    (pipe_out)
  );

  // --------------------------------------------------------------------------
  // output coding: core is offset binary
  // --------------------------------------------------------------------------
  always_comb begin
    fmt_word = pipe_out[`AFO_WORD_W-1:0];
    if (s_q.ctrl.fmt == AFO_FMT_TC_DCS_A || s_q.ctrl.fmt == AFO_FMT_TC_DCS_B) begin
      fmt_word[`AFO_WORD_W-1] = ~fmt_word[`AFO_WORD_W-1];
    end
    if (s_q.ctrl.scrm) begin
      fmt_word[`AFO_WORD_W-1:1] = fmt_word[`AFO_WORD_W-1:1]
                                 ^ {(`AFO_WORD_W-1){fmt_word[0]}};
    end
  end

  assign demux   = (s_q.ctrl.style == AFO_STYLE_DEMUX_SE);
  assign addr_ok = hsel & hready & htrans[1];

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.readyout = 1'b1;
    s_d.enc_prev = enc_level;

    // bus data phase write
    if (s_q.dph_wr) begin
      unique case (s_q.dph_addr)
        `AFO_CTRL_OFS: begin
          s_d.ctrl.pdn   = hwdata[`AFO_CTRL_PDN_BIT];
          s_d.ctrl.dither_enable_pin  = hwdata[`AFO_CTRL_DITHER_ENABLE_PIN_BIT];
          s_d.ctrl.scrm  = hwdata[`AFO_CTRL_SCRM_BIT];
          s_d.ctrl.gain  = hwdata[`AFO_CTRL_GAIN_BIT];
          s_d.ctrl.style = afo_style_t'(hwdata[`AFO_CTRL_STYLE_LSB +: 2]);
          s_d.ctrl.fmt   = afo_fmt_t'(hwdata[`AFO_CTRL_FMT_LSB +: 2]);
        end
        `AFO_SCOUNT_OFS: begin
          s_d.scount = '0;
        end
        `AFO_RCOUNT_OFS: begin
          s_d.rcount = '0;
        end
        default: begin
        end
      endcase
    end

    // counters: a sample in the clearing cycle still counts
    if (sample_adv) begin
      s_d.scount = s_d.scount + 32'h00000001;
      if (pipe_out[`AFO_WORD_W]) begin
        s_d.rcount = s_d.rcount + 32'h00000001;
      end
    end

    // output stage
    if (s_q.ctrl.pdn) begin
      s_d.strobe_b    = 1'b0;
      s_d.demux_phase = 1'b0;
    end else if (enc_rise) begin
      if (demux) begin
        if (!s_q.demux_phase) begin
          s_d.hold_word   = fmt_word;
          s_d.hold_rng    = pipe_out[`AFO_WORD_W];
          s_d.demux_phase = 1'b1;
          s_d.strobe_b    = 1'b0;
        end else begin
          s_d.bus_a       = s_q.hold_word;
          s_d.rng_a       = s_q.hold_rng;
          s_d.bus_b       = fmt_word;
          s_d.rng_b       = pipe_out[`AFO_WORD_W];
          s_d.demux_phase = 1'b0;
          s_d.strobe_b    = 1'b1;
        end
      end else begin
        s_d.bus_a       = fmt_word;
        s_d.rng_a       = pipe_out[`AFO_WORD_W];
        s_d.demux_phase = 1'b0;
        s_d.strobe_b    = 1'b1;
      end
    end else if (enc_fall && !demux) begin
      s_d.strobe_b = 1'b0;
    end

    // drivers and analog controls follow the control register
    s_d.oe_a     = ~s_q.ctrl.pdn;
    s_d.oe_clk   = ~s_q.ctrl.pdn;
    s_d.oe_b     = ~s_q.ctrl.pdn & demux;
    s_d.pdn_out  = s_q.ctrl.pdn;
    s_d.dither_enable_pin_out = s_q.ctrl.dither_enable_pin;
    s_d.gain_out = s_q.ctrl.gain;
    s_d.dcs_out  = (s_q.ctrl.fmt != AFO_FMT_OB_NODCS);

    // address phase: capture and prepare read data
    s_d.dph_wr   = addr_ok & hwrite;
    s_d.dph_addr = haddr[7:0];
    if (addr_ok && !hwrite) begin
      unique case (haddr[7:0])
        `AFO_CTRL_OFS: begin
          s_d.rdata = {24'h000000, s_d.ctrl.fmt, s_d.ctrl.style, s_d.ctrl.gain,
                       s_d.ctrl.scrm, s_d.ctrl.dither_enable_pin, s_d.ctrl.pdn};
        end
        `AFO_STATUS_OFS: begin
          s_d.rdata = {26'h0000000, s_q.dcs_out, s_q.oe_b, s_q.oe_a,
                       s_q.strobe_b, s_q.demux_phase, enc_level};
        end
        `AFO_SCOUNT_OFS: begin
          s_d.rdata = s_d.scount;
        end
        `AFO_RCOUNT_OFS: begin
          s_d.rdata = s_d.rcount;
        end
        `AFO_LASTWORD_OFS: begin
          s_d.rdata = {s_q.bus_b, s_q.bus_a};
        end
        default: begin
          s_d.rdata = 32'h00000000;
        end
      endcase
    end else begin
      s_d.rdata = 32'h00000000;
    end
  end

  // --------------------------------------------------------------------------
  // state register
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q      <= '0;
      s_q.ctrl <= afo_ctrl_t'(`AFO_CTRL_RESET);
    end else begin
      s_q <= s_d;
    end
  end

  // --------------------------------------------------------------------------
  // outputs straight from the state register; hresp tied low
  // --------------------------------------------------------------------------
  assign hreadyout                  = s_q.readyout;
  assign hrdata                     = s_q.rdata;
  assign hresp                      = 1'b0;
  assign first_output_bus           = s_q.bus_a;
  assign first_output_bus_oe        = s_q.oe_a;
  assign second_output_bus          = s_q.bus_b;
  assign second_output_bus_oe       = s_q.oe_b;
  assign first_bus_range_flag       = s_q.rng_a;
  assign first_bus_range_flag_oe    = s_q.oe_a;
  assign second_bus_range_flag      = s_q.rng_b;
  assign second_bus_range_flag_oe   = s_q.oe_b;
  assign second_bus_valid_strobe    = s_q.strobe_b;
  assign second_bus_valid_strobe_oe = s_q.oe_clk;
  assign first_bus_valid_strobe     = ~s_q.strobe_b;
  assign first_bus_valid_strobe_oe  = s_q.oe_clk;
  assign analog_power_down          = s_q.pdn_out;
  assign dither_enable              = s_q.dither_enable_pin_out;
  assign gain_high                  = s_q.gain_out;
  assign duty_stabilizer_en         = s_q.dcs_out;

endmodule // afo_formatter

// >>> design/afo_consts.svh
// afo_consts.svh: offsets, field positions, reset values and counts of the output formatter
// assumes: included by bare name from the package and the design modules
`ifndef AFO_CONSTS_SVH
`define AFO_CONSTS_SVH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define AFO_CTRL_OFS        8'h00
`define AFO_STATUS_OFS      8'h04
`define AFO_SCOUNT_OFS      8'h08
`define AFO_RCOUNT_OFS      8'h0C
`define AFO_LASTWORD_OFS    8'h10

// ----------------------------------------------------------------------------
// control field positions and reset value
// ----------------------------------------------------------------------------
`define AFO_CTRL_PDN_BIT    0
`define AFO_CTRL_DITHER_ENABLE_PIN_BIT   1
`define AFO_CTRL_SCRM_BIT   2
`define AFO_CTRL_GAIN_BIT   3
`define AFO_CTRL_STYLE_LSB  4
`define AFO_CTRL_FMT_LSB    6
`define AFO_CTRL_RESET      8'h00

// ----------------------------------------------------------------------------
// widths and counts
// ----------------------------------------------------------------------------
`define AFO_WORD_W          16
`define AFO_LATENCY         7
`define AFO_SYNC_STAGES     2

`endif

// >>> design/afo_pkg.sv
// afo_pkg.sv: types of the output formatter
// assumes: afo_consts.svh sits on the include path
`include "afo_consts.svh"

package afo_pkg;

  // --------------------------------------------------------------------------
  // level-coded selects: 0 = ground, 1 = one third, 2 = two thirds, 3 = supply
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    AFO_STYLE_FULL_SE,
    AFO_STYLE_DEMUX_SE,
    AFO_STYLE_LP_DIFF,
    AFO_STYLE_STD_DIFF
  } afo_style_t;

  typedef enum logic [1:0] {
    AFO_FMT_OB_NODCS,
    AFO_FMT_OB_DCS,
    AFO_FMT_TC_DCS_A,
    AFO_FMT_TC_DCS_B
  } afo_fmt_t;

  typedef struct packed {
    logic                      pdn;
    logic                      dither_enable_pin;
    logic                      scrm;
    logic                      gain;
    afo_style_t                style;
    afo_fmt_t                  fmt;
  } afo_ctrl_t;

  typedef struct packed {
    // bus side
    logic                      dph_wr;
    logic [7:0]                dph_addr;
    logic [31:0]               rdata;
    logic                      readyout;
    // control and counters
    afo_ctrl_t                 ctrl;
    logic [31:0]               scount;
    logic [31:0]               rcount;
    // encode edge tracking
    logic                      enc_prev;
    logic                      demux_phase;
    logic [`AFO_WORD_W-1:0]    hold_word;
    logic                      hold_rng;
    // pins
    logic [`AFO_WORD_W-1:0]    bus_a;
    logic [`AFO_WORD_W-1:0]    bus_b;
    logic                      rng_a;
    logic                      rng_b;
    logic                      strobe_b;
    logic                      oe_a;
    logic                      oe_b;
    logic                      oe_clk;
    logic                      pdn_out;
    logic                      dither_enable_pin_out;
    logic                      gain_out;
    logic                      dcs_out;
  } afo_state_t;

endpackage

// >>> design/afo_sync.sv
// afo_sync.sv: two-flop synchroniser for pins from outside the hclk domain
// assumes: inputs are levels that stay stable for several hclk periods
module afo_sync #(
  parameter int W = 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } afo_sync_state_t;

  afo_sync_state_t s_q;
  afo_sync_state_t s_d;

  // --------------------------------------------------------------------------
  // two stages; only the second is read
  // --------------------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.meta   = async_in;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stable;

endmodule // afo_sync

// >>> design/afo_delay.sv
// afo_delay.sv: sample pipeline that advances once per encode rising edge
// assumes: adv is a one-cycle pulse in the hclk domain
`include "afo_consts.svh"

module afo_delay #(
  parameter int DEPTH = `AFO_LATENCY,
  parameter int W     = `AFO_WORD_W + 1
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         adv,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] stage;
  } afo_delay_state_t;

  afo_delay_state_t s_q;
  afo_delay_state_t s_d;

  // --------------------------------------------------------------------------
  // shift on each sample; dout is the word taken DEPTH samples earlier
  // --------------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    if (adv) begin
      s_d.stage[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
        s_d.stage[i] = s_q.stage[i-1];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stage[DEPTH-1];

endmodule // afo_delay

// >>> sim/afo_formatter_sva.sv
// afo_formatter_sva.sv: pin-level assertions on the output formatter
// assumes: bound to afo_formatter; control is shadowed from its bus inputs
module afo_formatter_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        encode_clock_pos,
  input wire logic        first_output_bus_oe,
  input wire logic        second_output_bus_oe,
  input wire logic        first_bus_range_flag_oe,
  input wire logic        second_bus_range_flag_oe,
  input wire logic        first_bus_valid_strobe,
  input wire logic        first_bus_valid_strobe_oe,
  input wire logic        second_bus_valid_strobe,
  input wire logic        second_bus_valid_strobe_oe,
  input wire logic        analog_power_down,
  input wire logic        dither_enable,
  input wire logic        gain_high,
  input wire logic        duty_stabilizer_en
);
  logic       wr_q;
  logic [7:0] ctl_q;
  logic [5:0] age_q;
  logic [2:0] enc_q;
  logic       stab;
  logic       live;
  logic       done;
  logic       rise;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ----
  // control shadow, settle counter, encode edge
  // ----
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q  <= 1'b0;
      ctl_q <= 8'h00;
      age_q <= 6'h00;
      enc_q <= 3'h0;
    end else begin
      wr_q  <= hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
      enc_q <= {enc_q[1:0], encode_clock_pos};
      if (wr_q) ctl_q <= hwdata[7:0];
      if (wr_q && hwdata[7:0] != ctl_q) age_q <= 6'h00;
      else if (age_q != 6'h3F) age_q <= age_q + 6'h01;
    end
  end
  assign stab = age_q > 6'h01;
  assign live = stab && !ctl_q[0];
  assign done = age_q == 6'h3F && !ctl_q[0];
  assign rise = enc_q[1] && !enc_q[2];
  // ----
  // assertions
  // ----
  a_pdn_pin: assert property (
    stab |-> analog_power_down == ctl_q[0]) else $error("power down level wrong");
  a_pdn_tristate: assert property (
    stab && ctl_q[0] |-> !(first_output_bus_oe || second_output_bus_oe ||
      first_bus_valid_strobe_oe || second_bus_valid_strobe_oe))
    else $error("output driven in power down");
  a_dither_pin: assert property (
    stab |-> dither_enable == ctl_q[1]) else $error("dither level wrong");
  a_gain_pin: assert property (
    stab |-> gain_high == ctl_q[3]) else $error("gain level wrong");
  a_fmt_stabilizer: assert property (
    stab |-> duty_stabilizer_en == (ctl_q[7:6] != 2'h0)) else $error("stabilizer wrong");
  a_second_bus_mode: assert property (
    live |-> second_output_bus_oe == (ctl_q[5:4] == 2'h1)) else $error("second bus oe wrong");
  a_first_bus_on: assert property (
    live |-> first_output_bus_oe && first_bus_valid_strobe_oe && second_bus_valid_strobe_oe)
    else $error("first bus not driven");
  a_range_flag_oe: assert property (
    first_bus_range_flag_oe == first_output_bus_oe &&
    second_bus_range_flag_oe == second_output_bus_oe) else $error("range flag oe wrong");
  a_strobe_inverse: assert property (
    first_bus_valid_strobe == !second_bus_valid_strobe) else $error("strobes not inverse");
  a_full_rate_strobe: assert property (
    done && ctl_q[5:4] != 2'h1 && rise |->
      ##[1:4] ($rose(second_bus_valid_strobe) || age_q != 6'h3F))
    else $error("strobe missed a sample");
  a_demux_strobe: assert property (
    done && ctl_q[5:4] == 2'h1 && rise |->
      ##[1:4] ($changed(second_bus_valid_strobe) || age_q != 6'h3F))
    else $error("demux strobe missed a sample");
endmodule // afo_formatter_sva

bind afo_formatter afo_formatter_sva u_afo_formatter_sva (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .encode_clock_pos,
  .first_output_bus_oe, .second_output_bus_oe, .first_bus_range_flag_oe,
  .second_bus_range_flag_oe, .first_bus_valid_strobe, .first_bus_valid_strobe_oe,
  .second_bus_valid_strobe, .second_bus_valid_strobe_oe, .analog_power_down,
  .dither_enable, .gain_high, .duty_stabilizer_en
);

// >>> sim/afo_capture.sv
// afo_capture.sv: capture receiver latching words on the valid strobes
// assumes: bus levels already resolved; stamp counts encode rises
module afo_capture (
  input  wire logic        strobe_a,
  input  wire logic        strobe_b,
  input  wire logic        descramble,
  input  wire logic [15:0] stamp,
  input  wire logic [15:0] bus_a,
  input  wire logic [15:0] bus_b,
  input  wire logic        flag_a,
  input  wire logic        flag_b,
  output logic      [15:0] word_a,
  output logic      [15:0] word_b,
  output logic      [15:0] word_alt,
  output logic             got_a,
  output logic             got_b,
  output logic      [15:0] got_stamp,
  output int               got_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  function automatic logic [15:0] undo(input logic [15:0] w);
    return descramble ? {w[15:1] ^ {15{w[0]}}, w[0]} : w;
  endfunction
  always @(posedge strobe_b) got_stamp = stamp;
  always @(negedge strobe_b) begin
    word_a = undo(bus_a);
    word_b = undo(bus_b);
    got_a = flag_a;
    got_b = flag_b;
    got_cnt++;
  end
  always @(posedge strobe_a) word_alt = undo(bus_a);
endmodule // afo_capture

// >>> sim/afo_formatter_bench.sv
// afo_formatter_bench.sv: self-checking bench of the output formatter
// assumes: design files compiled first; capture model and checker beside it
module afo_formatter_bench;
  import afo_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic        encode_clock_pos = 1'b0;
  logic        descr = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [15:0] n_rise = 16'h0000, core_word, first_output_bus, second_output_bus, wa, wb;
  logic [15:0] word_a, word_b, word_alt, got_stamp;
  logic        hready, hreadyout, hresp, encode_clock_neg, core_range, got_a, got_b;
  logic        first_output_bus_oe, second_output_bus_oe, first_bus_range_flag;
  logic        second_bus_range_flag, first_bus_range_flag_oe, second_bus_range_flag_oe;
  logic        first_bus_valid_strobe, first_bus_valid_strobe_oe, second_bus_valid_strobe;
  logic        second_bus_valid_strobe_oe, analog_power_down, dither_enable, gain_high;
  logic        duty_stabilizer_en;
  int          err_total = 0, checks = 0, got_cnt;
  function automatic logic [15:0] vw(input logic [15:0] n);
    return n * 16'h2B5D;
  endfunction
  function automatic logic [15:0] fmtd(input logic [15:0] n, input logic tc);
    return vw(n) ^ {tc, 15'h0000};
  endfunction
  // ----
  // clocks, sample source, wires
  // ----
  always #4 hclk = ~hclk;
  initial begin
    #3;
    forever #32 encode_clock_pos = ~encode_clock_pos;
  end
  always @(posedge encode_clock_pos) n_rise <= n_rise + 16'h0001;
  assign encode_clock_neg = ~encode_clock_pos;
  assign core_word = vw(n_rise);
  assign core_range = n_rise[2];
  assign hready = hreadyout;
  assign wa = first_output_bus_oe ? first_output_bus : ~first_output_bus;
  assign wb = second_output_bus_oe ? second_output_bus : ~second_output_bus;
  afo_formatter #(.LATENCY(7)) u_afo_formatter (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hrdata, .hresp, .encode_clock_pos, .encode_clock_neg, .core_word, .core_range,
    .first_output_bus, .first_output_bus_oe, .second_output_bus, .second_output_bus_oe,
    .first_bus_range_flag, .first_bus_range_flag_oe, .second_bus_range_flag,
    .second_bus_range_flag_oe, .first_bus_valid_strobe, .first_bus_valid_strobe_oe,
    .second_bus_valid_strobe, .second_bus_valid_strobe_oe, .analog_power_down,
    .dither_enable, .gain_high, .duty_stabilizer_en
  );
  afo_capture u_afo_capture (
    .strobe_a(first_bus_valid_strobe), .strobe_b(second_bus_valid_strobe),
    .descramble(descr), .stamp(n_rise), .bus_a(wa), .bus_b(wb),
    .flag_a(first_bus_range_flag), .flag_b(second_bus_range_flag),
    .word_a, .word_b, .word_alt, .got_a, .got_b, .got_stamp, .got_cnt
  );
  // ----
  // shared tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_idle;
    logic [31:0] r;
    ahb(32'h40, 1'b0, 32'h0, r);
    check(r, 32'h0);
    check(32'(first_output_bus_oe), 32'h1);
    check(32'(second_output_bus_oe), 32'h0);
  endtask
  task automatic t_modes;
    logic [31:0] r;
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {24'h0, 2'(i), 2'(i), i[0], 1'b0, i[1], 1'b0};
      ahb(32'h0, 1'b1, d, r);
      ahb(32'h0, 1'b0, 32'h0, r);
      check(r, d);
      check(32'(dither_enable), 32'(i[1]));
      check(32'(gain_high), 32'(i[0]));
      check(32'(duty_stabilizer_en), 32'(i != 0));
      check(32'(second_output_bus_oe), 32'(i == 1));
      check(32'(first_output_bus_oe), 32'h1);
    end
  endtask
  task automatic t_stream(input logic [1:0] st, input logic [1:0] fm, input logic sc);
    logic [31:0] r;
    logic [15:0] k;
    logic [15:0] ea;
    int          c;
    ahb(32'h0, 1'b1, {24'h0, fm, st, 1'b0, sc, 2'b00}, r);
    descr = sc;
    repeat (200) @(posedge hclk);
    for (int j = 0; j < 6; j++) begin
      c = got_cnt;
      while (got_cnt == c) @(posedge hclk);
      @(posedge hclk);
      k = got_stamp;
      if (st == 2'h1) begin
        ea = fmtd(k - 16'h0008, fm[1]);
        check(32'(word_a), 32'(ea));
        check(32'(word_b), 32'(fmtd(k - 16'h0007, fm[1])));
        check(32'(got_b), 32'(k[3:0] - 4'h7 >> 2 & 4'h1));
        check(32'(got_a), 32'(k[3:0] - 4'h8 >> 2 & 4'h1));
      end else begin
        ea = fmtd(k - 16'h0007, fm[1]);
        check(32'(word_a), 32'(ea));
        check(32'(got_a), 32'(k[3:0] - 4'h7 >> 2 & 4'h1));
      end
      check(32'(word_alt), 32'(ea));
    end
  endtask
  task automatic t_pdn;
    logic [31:0] r;
    int          c;
    ahb(32'h0, 1'b1, 32'h1, r);
    repeat (3) @(posedge hclk);
    c = got_cnt;
    check(32'(analog_power_down), 32'h1);
    check(32'({first_output_bus_oe, second_output_bus_oe, first_bus_valid_strobe_oe}), 32'h0);
    repeat (100) @(posedge hclk);
    check(got_cnt, c);
    ahb(32'h0, 1'b1, 32'h0, r);
    repeat (3) @(posedge hclk);
    check(32'(first_output_bus_oe), 32'h1);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_idle;
    t_modes;
    t_stream(2'h0, 2'h0, 1'b0);
    t_stream(2'h0, 2'h2, 1'b1);
    t_stream(2'h1, 2'h3, 1'b1);
    t_stream(2'h1, 2'h1, 1'b0);
    t_stream(2'h3, 2'h0, 1'b1);
    t_pdn;
    wrap_up;
  end
  initial begin
    #60000;
    err_total++;
    wrap_up;
  end
endmodule // afo_formatter_bench
